// [rtl/rxbuf_pkg.sv]
/*
  Shared constants for the receive and transmit buffer bookkeeping block:
  register offsets, field positions, reset values and buffer sizes.
  Assumes every file that uses it imports the whole package.
*/
package rxbuf_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RX_BYTE_STATUS   = 8'h19;
  localparam logic [7:0] ADDR_RX_FREE_SPACE    = 8'h1b;
  localparam logic [7:0] ADDR_TX_QUEUE_SEL     = 8'h95;
  localparam logic [7:0] ADDR_RX_READ_INDEX    = 8'h97;
  localparam logic [7:0] ADDR_RX_WRITE_INDEX   = 8'h99;
  localparam logic [7:0] ADDR_RX_NEXT_MSG      = 8'h9b;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_MSG_START  = 2;
  localparam int BIT_SUSPECT    = 1;
  localparam int BIT_MSG_END    = 0;
  localparam int SEND_Q_LSB     = 2;
  localparam int LOAD_Q_LSB     = 0;
  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int         RX_DEPTH        = 62;
  localparam logic [7:0] RX_LAST_INDEX   = 8'h3d;
  localparam logic [7:0] RST_FREE_SPACE  = 8'h3e;
  localparam logic [7:0] RST_READ_INDEX  = 8'h00;
  localparam logic [7:0] RST_WRITE_INDEX = 8'h01;
  localparam logic [7:0] RST_NEXT_MSG    = 8'h00;
  localparam logic [1:0] RST_QUEUE       = 2'h0;
  localparam logic [7:0] NULL_BYTE       = 8'h00;
  localparam int         ENTRY_W         = 11;
  localparam int         IN_FIFO_W       = 11;
  localparam int         IN_FIFO_DEPTH   = 16;
endpackage

// [rtl/stream_fifo.sv]
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module stream_fifo #(
  parameter int W     = 11,
  parameter int DEPTH = 16
) (
  input  wire logic         CLOCK,
  input  wire logic         RST,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] store_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0]   count_ff;
  logic [AW:0]   nxt_count;
  logic          in_ready_ff;
  logic          push;
  logic          pop;

  // Ready is registered so the port comes straight from a flop
  assign in_ready  = in_ready_ff;
  assign out_valid = (count_ff != '0);
  assign out_data  = store_ff[rd_ptr_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write, no reset needed on the data array
  always_ff @(posedge CLOCK) begin
    if (push) begin
      store_ff[wr_ptr_ff] <= in_data;
    end
  end

  // Occupancy after this edge
  always_comb begin
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = count_ff + (AW+1)'(1);
    end else if (pop && !push) begin
      nxt_count = count_ff - (AW+1)'(1);
    end
  end

  // Pointers, count and registered ready; full is known one edge ahead
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      wr_ptr_ff   <= '0;
      rd_ptr_ff   <= '0;
      count_ff    <= '0;
      in_ready_ff <= 1'b1;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + AW'(1);
      if (pop)  rd_ptr_ff <= rd_ptr_ff + AW'(1);
      count_ff    <= nxt_count;
      in_ready_ff <= (nxt_count != (AW+1)'(DEPTH));
    end
  end
endmodule
`default_nettype wire

// [rtl/rx_store.sv]
/*
  Receive buffer storage: one write port, one read port whose data
  come out of a register. Assumes addresses stay below DEPTH.
*/
`timescale 1ns/100ps
`default_nettype none
module rx_store #(
  parameter int W     = 11,
  parameter int DEPTH = 62
) (
  input  wire logic         CLOCK,
  input  wire logic         RST,
  input  wire logic         we,
  input  wire logic [7:0]   waddr,
  input  wire logic [W-1:0] wdata,
  input  wire logic [7:0]   raddr,
  output logic [W-1:0]      rdata_ff
);
  logic [W-1:0] mem_ff [DEPTH];

  // Write port; cleared at reset so an unwritten slot never shows status.
  // Costs a reset on every cell, which is cheap at this depth.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
    end else if (we) begin
      mem_ff[waddr[5:0]] <= wdata;
    end
  end

  // Registered read port, reset so the first status shows zero
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= mem_ff[raddr[5:0]];
    end
  end
endmodule
`default_nettype wire

// [rtl/rxbuf_keeper.sv]
/*
  Receive buffer pointers, per-byte status, free space, transmit queue
  selects and the receive-error interrupt flag of the bridge.
  Assumes the SPI decoder and the UART run on CLOCK and give one-cycle
  command pulses; nothing here crosses a clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module rxbuf_keeper
  import rxbuf_pkg::*;
(
  input  wire logic       CLOCK,
  input  wire logic       RST,
  // Received characters from the UART decoder
  input  wire logic       RX_VALID,
  output logic            RX_READY,
  input  wire logic [7:0] RX_CHAR,
  input  wire logic       RX_AFTER_PREAMBLE,
  input  wire logic       RX_CODE_ERROR,
  input  wire logic       RX_STOP_CHAR,
  // Host commands decoded from SPI
  input  wire logic       RD_BYTE,
  input  wire logic       JUMP_TO_NEXT_MESSAGE_COMMAND,
  input  wire logic       LOAD_QUEUE_WR,
  input  wire logic [1:0] LOAD_QUEUE_DATA,
  input  wire logic [1:0] SEND_QUEUE,
  input  wire logic       ERR_INT_ENABLE,
  input  wire logic       ERR_FLAG_WRITE_ZERO,
  input  wire logic       REG_RD,
  input  wire logic [7:0] REG_ADDR,
  output logic [7:0]      REG_RDATA,
  output logic            REG_RVALID,
  output logic [7:0]      RX_BYTE,
  output logic            ERR_FLAG,
  output logic            INT_N
);
  // ----------------------------------------------------------------
  // Index arithmetic
  // ----------------------------------------------------------------
  // Next location, wrapping inside the 62-byte buffer
  function automatic logic [7:0] inc_idx(input logic [7:0] i);
    return (i == RX_LAST_INDEX) ? 8'h00 : i + 8'h01;
  endfunction

  // Forward distance from a to b around the buffer
  function automatic logic [7:0] fwd_dist(input logic [7:0] a, input logic [7:0] b);
    return (b >= a) ? b - a : 8'(b + 8'(RX_DEPTH) - a);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [IN_FIFO_W-1:0] fifo_in;
  logic [IN_FIFO_W-1:0] fifo_out;
  logic                 fifo_valid;
  logic                 fifo_ready;
  logic [ENTRY_W-1:0]   wr_entry;
  logic [ENTRY_W-1:0]   rd_entry;
  logic [7:0]           read_idx_ff;
  logic [7:0]           nxt_read_idx;
  logic [7:0]           write_idx_ff;
  logic [7:0]           next_msg_ff;
  logic                 msg_pending_ff;
  logic [7:0]           free_ff;
  logic [7:0]           nxt_free;
  logic [1:0]           load_q_ff;
  logic [1:0]           send_q_ff;
  logic                 err_prev_ff;
  logic                 nxt_flag;
  logic                 flag_ff;
  logic [7:0]           rdata_ff;
  logic                 rvalid_ff;
  logic                 int_n_ff;
  logic                 store;
  logic                 consume;
  logic                 jump;
  logic                 stop_in;
  logic                 have_data;
  logic                 st_first;
  logic                 st_err;
  logic                 st_last;
  logic                 err_rise;
  logic [7:0]           byte_status;
  logic [7:0]           queue_sel;

  // ----------------------------------------------------------------
  // Input FIFO
  // ----------------------------------------------------------------
  // Sixteen characters of slack while the host is slow to read
  assign fifo_in = {RX_STOP_CHAR, RX_CODE_ERROR, RX_AFTER_PREAMBLE, RX_CHAR};

  stream_fifo #(
    .W     (IN_FIFO_W),
    .DEPTH (IN_FIFO_DEPTH)
  ) u_in_fifo (
    .CLOCK     (CLOCK),
    .RST       (RST),
    .in_valid  (RX_VALID),
    .in_ready  (RX_READY),
    .in_data   (fifo_in),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_out)
  );

  // ----------------------------------------------------------------
  // Store and consume decisions
  // ----------------------------------------------------------------
  // Draining stalls when no byte is free, so back-pressure reaches the UART
  assign fifo_ready = (free_ff != 8'h00);
  assign store      = fifo_valid && fifo_ready;
  assign stop_in    = fifo_out[10];
  assign have_data  = (free_ff != RST_FREE_SPACE);
  assign jump       = JUMP_TO_NEXT_MESSAGE_COMMAND;
  // A jump in the same cycle overrides a byte read
  assign consume    = RD_BYTE && have_data && !jump;
  // Stop characters land as a null byte with the end mark kept beside it
  assign wr_entry   = {fifo_out[10:8], stop_in ? NULL_BYTE : fifo_out[7:0]};

  // ----------------------------------------------------------------
  // Buffer storage
  // ----------------------------------------------------------------
  // Read address is the next index, so the output lines up with it
  rx_store #(
    .W     (ENTRY_W),
    .DEPTH (RX_DEPTH)
  ) u_store (
    .CLOCK    (CLOCK),
    .RST      (RST),
    .we       (store),
    .waddr    (write_idx_ff),
    .wdata    (wr_entry),
    .raddr    (nxt_read_idx),
    .rdata_ff (rd_entry)
  );

  // ----------------------------------------------------------------
  // Pointers
  // ----------------------------------------------------------------
  // Read index steps forward before the host sees the next byte
  always_comb begin
    nxt_read_idx = read_idx_ff;
    if (jump) begin
      nxt_read_idx = next_msg_ff;
    end else if (consume) begin
      nxt_read_idx = inc_idx(read_idx_ff);
    end
  end

  // Read index register
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      read_idx_ff <= RST_READ_INDEX;
    end else begin
      read_idx_ff <= nxt_read_idx;
    end
  end

  // Write index advances with every stored byte
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      write_idx_ff <= RST_WRITE_INDEX;
    end else if (store) begin
      write_idx_ff <= inc_idx(write_idx_ff);
    end
  end

  // Next-message mark: follows stored bytes until a stop freezes it.
  // Only the first unread message boundary is tracked; a jump frees it.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      next_msg_ff    <= RST_NEXT_MSG;
      msg_pending_ff <= 1'b0;
    end else begin
      if (store && (!msg_pending_ff || jump)) begin
        next_msg_ff    <= write_idx_ff;
        msg_pending_ff <= stop_in;
      end else if (jump) begin
        msg_pending_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Free space
  // ----------------------------------------------------------------
  // Skipped bytes on a jump are returned to the free pool
  always_comb begin
    nxt_free = free_ff;
    if (jump) begin
      nxt_free = 8'(nxt_free + fwd_dist(read_idx_ff, next_msg_ff));
    end else if (consume) begin
      nxt_free = nxt_free + 8'h01;
    end
    if (store) begin
      nxt_free = nxt_free - 8'h01;
    end
  end

  // Free space register
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      free_ff <= RST_FREE_SPACE;
    end else begin
      free_ff <= nxt_free;
    end
  end

  // ----------------------------------------------------------------
  // Byte status
  // ----------------------------------------------------------------
  // Levels of the entry at the read index, kept after the buffer drains
  assign st_first    = rd_entry[8];
  assign st_err      = rd_entry[9];
  assign st_last     = rd_entry[10];
  assign byte_status = {5'h00, st_first, st_err, st_last};

  // ----------------------------------------------------------------
  // Queue selects
  // ----------------------------------------------------------------
  // Host loading choice and UART sending choice
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      load_q_ff <= RST_QUEUE;
      send_q_ff <= RST_QUEUE;
    end else begin
      if (LOAD_QUEUE_WR) load_q_ff <= LOAD_QUEUE_DATA;
      send_q_ff <= SEND_QUEUE;
    end
  end

  assign queue_sel = {4'h0, send_q_ff, load_q_ff};

  // ----------------------------------------------------------------
  // Receive-error flag and pin
  // ----------------------------------------------------------------
  // Edge only, so a level already high when enabled or cleared is ignored
  assign err_rise = st_err && !err_prev_ff;

  always_comb begin
    nxt_flag = flag_ff;
    if (ERR_FLAG_WRITE_ZERO) begin
      nxt_flag = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (ERR_INT_ENABLE && err_rise) begin
      nxt_flag = 1'b1;
    end
  end

  // Flag, edge history and active-low pin
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      err_prev_ff <= 1'b0;
      flag_ff     <= 1'b0;
      int_n_ff    <= 1'b1;
    end else begin
      err_prev_ff <= st_err;
      flag_ff     <= nxt_flag;
      int_n_ff    <= !nxt_flag;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  // One-cycle answer; unmapped offsets read as zero
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= REG_RD;
      if (REG_RD) begin
        case (REG_ADDR)
          ADDR_RX_BYTE_STATUS: rdata_ff <= byte_status;
          ADDR_RX_FREE_SPACE:  rdata_ff <= free_ff;
          ADDR_TX_QUEUE_SEL:   rdata_ff <= queue_sel;
          ADDR_RX_READ_INDEX:  rdata_ff <= read_idx_ff;
          ADDR_RX_WRITE_INDEX: rdata_ff <= write_idx_ff;
          ADDR_RX_NEXT_MSG:    rdata_ff <= next_msg_ff;
          default:             rdata_ff <= 8'h00;
        endcase
      end
    end
  end

  assign REG_RDATA  = rdata_ff;
  assign REG_RVALID = rvalid_ff;
  assign RX_BYTE    = rd_entry[7:0];
  assign ERR_FLAG   = flag_ff;
  assign INT_N      = int_n_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence err_edge_s;
    ERR_INT_ENABLE && st_err && !err_prev_ff;
  endsequence

  sequence status_read_s;
    REG_RD && (REG_ADDR == ADDR_RX_BYTE_STATUS);
  endsequence

  stop_null_a: assert property (store && stop_in |-> wr_entry[7:0] == NULL_BYTE)
    else $error("stop character not stored as null");
  status_read_a: assert property (status_read_s |=> REG_RDATA == $past(byte_status))
    else $error("byte status read mismatch");
  free_bound_a: assert property (free_ff <= RST_FREE_SPACE)
    else $error("free count above capacity");
  free_store_a: assert property (store && !consume && !jump |=> free_ff == $past(free_ff) - 8'h01)
    else $error("free count not decremented");
  read_step_a: assert property (consume |=> read_idx_ff == inc_idx($past(read_idx_ff)))
    else $error("read index did not advance");
  write_step_a: assert property (store |=> write_idx_ff == inc_idx($past(write_idx_ff)))
    else $error("write index did not advance");
  jump_copy_a: assert property (jump |=> read_idx_ff == $past(next_msg_ff))
    else $error("jump did not load next message start");
  flag_set_a: assert property (err_edge_s |=> flag_ff && !INT_N)
    else $error("error flag not set on enabled rise");
  flag_hold_a: assert property (flag_ff && !ERR_FLAG_WRITE_ZERO |=> flag_ff)
    else $error("error flag lost without clear");
  flag_quiet_a: assert property (!flag_ff && !(ERR_INT_ENABLE && err_rise) |=> !flag_ff)
    else $error("error flag set without rise");
  int_pin_a: assert property (INT_N == !flag_ff)
    else $error("interrupt pin disagrees with flag");
  queue_zero_a: assert property (REG_RD && REG_ADDR == ADDR_TX_QUEUE_SEL |=> REG_RDATA[7:4] == 4'h0)
    else $error("queue select upper bits not zero");
endmodule
`default_nettype wire

// [test/uart_char_source.sv]
/*
  Far-side model of the character stream: offers one received character
  at a time on the valid/ready port and holds it until it is taken.
  Assumes it is called at a falling edge of CLOCK and that RX_READY
  only moves on rising edges.
*/
`timescale 1ns/100ps
`default_nettype none
module uart_char_source (
  input  wire logic       CLOCK,
  input  wire logic       RX_READY,
  output logic            RX_VALID,
  output logic [7:0]      RX_CHAR,
  output logic            RX_AFTER_PREAMBLE,
  output logic            RX_CODE_ERROR,
  output logic            RX_STOP_CHAR
);
  // ----------------------------------------------------------------
  // Idle state at time zero
  // ----------------------------------------------------------------
  initial begin
    RX_VALID          = 1'b0;
    RX_CHAR           = 8'h00;
    RX_AFTER_PREAMBLE = 1'b0;
    RX_CODE_ERROR     = 1'b0;
    RX_STOP_CHAR      = 1'b0;
  end
  // Hold the offer until a rising edge sees ready high; ready is read
  // at the falling edge so the sample never races the edge itself
  task automatic put(input logic [7:0] c, input logic pre, input logic err,
                     input logic stp);
    logic taken;
    RX_VALID          = 1'b1;
    RX_CHAR           = c;
    RX_AFTER_PREAMBLE = pre;
    RX_CODE_ERROR     = err;
    RX_STOP_CHAR      = stp;
    taken             = 1'b0;
    while (!taken) begin
      taken = (RX_READY === 1'b1);
      @(negedge CLOCK);
    end
  endtask
  // Released lines show the inverse, never the stale character
  task automatic idle();
    RX_VALID          = 1'b0;
    RX_CHAR           = ~RX_CHAR;
    RX_AFTER_PREAMBLE = ~RX_AFTER_PREAMBLE;
    RX_CODE_ERROR     = ~RX_CODE_ERROR;
    RX_STOP_CHAR      = ~RX_STOP_CHAR;
  endtask
endmodule
`default_nettype wire

// [test/uart_buffer_pointer_status_tb_top.sv]
/*
  Self-checking bench for the receive buffer keeper: reset values,
  status bits, error flag, jump, queue selects, fill and drain.
  Assumes the keeper's register read answers one cycle after REG_RD.
*/
`timescale 1ns/100ps
`default_nettype none
module uart_buffer_pointer_status_tb_top;
  import rxbuf_pkg::*;
  logic       CLOCK, RST, RX_VALID, RX_READY, RX_AFTER_PREAMBLE, RX_CODE_ERROR;
  logic       RX_STOP_CHAR, RD_BYTE, JUMP_TO_NEXT_MESSAGE_COMMAND, LOAD_QUEUE_WR;
  logic       ERR_INT_ENABLE, ERR_FLAG_WRITE_ZERO, REG_RD, REG_RVALID, ERR_FLAG, INT_N;
  logic [1:0] LOAD_QUEUE_DATA, SEND_QUEUE;
  logic [7:0] RX_CHAR, REG_ADDR, REG_RDATA, RX_BYTE;
  logic [7:0] exp_q[$];
  logic [7:0] fill_q[$];
  logic [31:0] seed;
  int         err_count, checked;
  rxbuf_keeper i_dut (.CLOCK(CLOCK), .RST(RST), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
    .RX_CHAR(RX_CHAR), .RX_AFTER_PREAMBLE(RX_AFTER_PREAMBLE), .RX_CODE_ERROR(RX_CODE_ERROR),
    .RX_STOP_CHAR(RX_STOP_CHAR), .RD_BYTE(RD_BYTE),
    .JUMP_TO_NEXT_MESSAGE_COMMAND(JUMP_TO_NEXT_MESSAGE_COMMAND),
    .LOAD_QUEUE_WR(LOAD_QUEUE_WR), .LOAD_QUEUE_DATA(LOAD_QUEUE_DATA), .SEND_QUEUE(SEND_QUEUE),
    .ERR_INT_ENABLE(ERR_INT_ENABLE), .ERR_FLAG_WRITE_ZERO(ERR_FLAG_WRITE_ZERO),
    .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .RX_BYTE(RX_BYTE), .ERR_FLAG(ERR_FLAG), .INT_N(INT_N));
  uart_char_source i_src (.CLOCK(CLOCK), .RX_READY(RX_READY), .RX_VALID(RX_VALID),
    .RX_CHAR(RX_CHAR), .RX_AFTER_PREAMBLE(RX_AFTER_PREAMBLE), .RX_CODE_ERROR(RX_CODE_ERROR),
    .RX_STOP_CHAR(RX_STOP_CHAR));
  // ----------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------------------------------
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  // Whole run is a few hundred cycles; this bound is far past that
  initial begin
    #200us;
    err_count++;
    complete_run();
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Note the expectation; the monitor below compares the answer
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    REG_RD   = 1'b1;
    REG_ADDR = a;
    @(negedge CLOCK);
    REG_RD   = 1'b0;
    REG_ADDR = ~a;
    @(negedge CLOCK);
  endtask
  task automatic rd_byte(input logic [7:0] exp);
    RD_BYTE = 1'b1;
    @(negedge CLOCK);
    RD_BYTE = 1'b0;
    chk(RX_BYTE, exp);
    @(negedge CLOCK);
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge CLOCK);
  endtask
  task automatic complete_run();
    $display("counts: checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Answer stands one cycle, so exactly one falling edge sees it
  always @(negedge CLOCK) begin
    if (REG_RVALID === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("ERROR %0t: unexpected register answer", $time);
      end else begin
        chk(REG_RDATA, exp_q.pop_front());
      end
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    RST = 1'b1;
    {RD_BYTE, JUMP_TO_NEXT_MESSAGE_COMMAND, LOAD_QUEUE_WR} = 3'h0;
    {ERR_INT_ENABLE, ERR_FLAG_WRITE_ZERO, REG_RD} = 3'h0;
    LOAD_QUEUE_DATA = 2'h0;
    SEND_QUEUE      = 2'h0;
    REG_ADDR        = 8'h00;
    err_count       = 0;
    checked         = 0;
    seed            = 32'd45;
    repeat (12) @(posedge CLOCK);
    @(negedge CLOCK);
    RST = 1'b0;
    step(1);
    // Reset values and an unmapped offset
    rreg(ADDR_RX_FREE_SPACE, 8'h3e);
    rreg(ADDR_RX_READ_INDEX, 8'h00);
    rreg(ADDR_RX_WRITE_INDEX, 8'h01);
    rreg(ADDR_RX_NEXT_MSG, 8'h00);
    rreg(ADDR_RX_BYTE_STATUS, 8'h00);
    rreg(ADDR_TX_QUEUE_SEL, 8'h00);
    rreg(8'h55, 8'h00);
    chk({7'h0, INT_N}, 8'h01);
    $display("test reset done");
    // One whole message stored, then skipped by the jump
    i_src.put(8'h11, 1'b1, 1'b0, 1'b0);
    i_src.put(8'h22, 1'b0, 1'b1, 1'b0);
    i_src.put(8'h33, 1'b0, 1'b0, 1'b1);
    i_src.idle();
    step(4);
    rreg(ADDR_RX_FREE_SPACE, 8'h3b);
    rreg(ADDR_RX_WRITE_INDEX, 8'h04);
    JUMP_TO_NEXT_MESSAGE_COMMAND = 1'b1;
    step(1);
    JUMP_TO_NEXT_MESSAGE_COMMAND = 1'b0;
    step(1);
    rreg(ADDR_RX_READ_INDEX, 8'h03);
    rreg(ADDR_RX_FREE_SPACE, 8'h3e);
    $display("test jump done");
    // Status per byte and the error flag life cycle
    i_src.put(8'h5a, 1'b1, 1'b0, 1'b0);
    i_src.put(8'ha5, 1'b0, 1'b1, 1'b0);
    i_src.put(8'h77, 1'b0, 1'b0, 1'b1);
    i_src.put(8'h3c, 1'b0, 1'b1, 1'b0);
    i_src.idle();
    step(4);
    rd_byte(8'h5a);
    rreg(ADDR_RX_BYTE_STATUS, 8'h04);
    rd_byte(8'ha5);
    rreg(ADDR_RX_BYTE_STATUS, 8'h02);
    chk({7'h0, ERR_FLAG}, 8'h00);
    ERR_INT_ENABLE = 1'b1;
    step(3);
    chk({7'h0, ERR_FLAG}, 8'h00);
    rd_byte(NULL_BYTE);
    rreg(ADDR_RX_BYTE_STATUS, 8'h01);
    rd_byte(8'h3c);
    step(1);
    chk({7'h0, ERR_FLAG}, 8'h01);
    chk({7'h0, INT_N}, 8'h00);
    rreg(ADDR_RX_READ_INDEX, 8'h07);
    chk({7'h0, ERR_FLAG}, 8'h01);
    ERR_FLAG_WRITE_ZERO = 1'b1;
    step(1);
    ERR_FLAG_WRITE_ZERO = 1'b0;
    step(3);
    chk({7'h0, ERR_FLAG}, 8'h00);
    chk({7'h0, INT_N}, 8'h01);
    rd_byte(8'h3c);
    rreg(ADDR_RX_BYTE_STATUS, 8'h02);
    $display("test status done");
    // Every load and send queue value
    for (int i = 0; i < 4; i++) begin
      LOAD_QUEUE_DATA = i[1:0];
      SEND_QUEUE      = ~i[1:0];
      LOAD_QUEUE_WR   = 1'b1;
      step(1);
      LOAD_QUEUE_WR   = 1'b0;
      step(1);
      rreg(ADDR_TX_QUEUE_SEL, {4'h0, ~i[1:0], i[1:0]});
    end
    $display("test queues done");
    // Fill buffer and FIFO until refused, then drain across the wrap
    for (int i = 0; i < RX_DEPTH + IN_FIFO_DEPTH; i++) begin
      seed = xs(seed);
      fill_q.push_back(seed[7:0]);
      i_src.put(seed[7:0], 1'b0, 1'b0, 1'b0);
    end
    i_src.idle();
    step(4);
    chk({7'h0, RX_READY}, 8'h00);
    rreg(ADDR_RX_FREE_SPACE, 8'h00);
    while (fill_q.size() > 0) begin
      rd_byte(fill_q.pop_front());
    end
    step(3);
    rreg(ADDR_RX_FREE_SPACE, 8'h3e);
    rreg(ADDR_RX_READ_INDEX, 8'h17);
    rreg(ADDR_RX_WRITE_INDEX, 8'h18);
    $display("test fill done");
    complete_run();
  end
endmodule
`default_nettype wire
